// File: core/bfs_supervisor.sv
// Contract
// R1: Load reporting resumes once battery fault clears
// R2: Flag releases on chip-select fall if faultless
// R3: Under-battery blocks all six gate drives
// R4: Gates return to commanded state automatically
// R5: Bit 7 set while under-battery present
// R6: Under-battery suppresses open and shorted reports
// R7: Under-battery fault asserts the fault flag
// R8: Vanished under-battery not captured at read
// R9: Reference select picks internal or external
// R10: Bit 8 set while over-battery present
// R11: Over-battery forces all gate drives off
// R12: Bits 0 to 5 carry per-channel load faults
// R13: Battery comparators synchronised before use
`timescale 1ns/1ns
`default_nettype none
`include "bfs_cfg.svh"

module bfs_supervisor #(
  parameter int N_CH = `BFS_NUM_CH
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // Battery comparators, asynchronous
  input  wire logic                  uv_bat_in,
  input  wire logic                  ov_bat_in,
  // Pins from the controller side
  input  wire logic                  cs_n,
  input  wire logic                  ext_ref_select,
  // Channel logic on this clock
  input  wire logic [N_CH-1:0]       gate_cmd,
  input  wire logic [N_CH-1:0]       load_fault_in,
  input  wire logic                  other_fault_in,
  // Gate drives
  output var  logic [N_CH-1:0]       gate_drive_outputs,
  // Captured fault word
  output var  logic [`BFS_WORD_W-1:0] fault_word,
  // Reference mux select, high picks ext_ref_input
  output var  logic                  ref_select_ext,
  // Open-drain fault flag
  output var  logic                  fault_flag_n_o,
  output var  logic                  fault_flag_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [`BFS_SYNC_W-1:0] sync_s;
  logic                   uv_s;
  logic                   ov_s;
  logic                   cs_s;
  logic                   ref_s;

  bfs_sync #(
    .W       (`BFS_SYNC_W),
    .RST_VAL (`BFS_SYNC_RST)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({ext_ref_select, cs_n, ov_bat_in, uv_bat_in}), // [R13]
    .sync_out (sync_s)
  );

  assign uv_s  = sync_s[`BFS_SY_UV];
  assign ov_s  = sync_s[`BFS_SY_OV];
  assign cs_s  = sync_s[`BFS_SY_CS];
  assign ref_s = sync_s[`BFS_SY_REF];

  ////////////////////////////////////////////////////////////////////////////
  // State
  bfs_pkg::bfs_bat_e      bat_q,      bat_d;
  logic                   cs_prev_q,  cs_prev_d;
  logic [N_CH-1:0]        gate_q,     gate_d;
  logic [N_CH-1:0]        sticky_q,   sticky_d;
  logic [`BFS_WORD_W-1:0] word_q,     word_d;
  logic                   flag_q,     flag_d;
  logic                   flag_n_q,   flag_n_d;
  logic                   ref_q,      ref_d;

  logic                   cs_fall;
  logic                   bat_fault;
  logic                   fault_now;
  logic [N_CH-1:0]        load_cap;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // Over wins if both comparators ever read high together
    if (ov_s) begin
      bat_d = bfs_pkg::BFS_BAT_OVER;
    end else if (uv_s) begin
      bat_d = bfs_pkg::BFS_BAT_UNDER;
    end else begin
      bat_d = bfs_pkg::BFS_BAT_OK;
    end

    cs_prev_d = cs_s;
    cs_fall   = cs_prev_q & ~cs_s;
    bat_fault = (bat_q != bfs_pkg::BFS_BAT_OK);

    // Lockout, released without controller action
    case (bat_q)
      bfs_pkg::BFS_BAT_OK:    gate_d = gate_cmd;                 // [R4]
      bfs_pkg::BFS_BAT_UNDER: gate_d = '0;                       // [R3]
      bfs_pkg::BFS_BAT_OVER:  gate_d = '0;                       // [R11]
      default:                gate_d = '0;
    endcase

    // Load faults are dropped while the battery is out of range
    load_cap = (sticky_q | load_fault_in) & ~{N_CH{bat_fault}};  // [R6] [R1]
    // Set wins over the read that clears it
    sticky_d = (sticky_q & ~{N_CH{cs_fall}}) |
               (load_fault_in & ~{N_CH{bat_fault}});

    // Capture at chip-select fall; battery bits are live, so a gone fault is not seen
    word_d = word_q;
    if (cs_fall) begin
      word_d                                      = '0;
      word_d[`BFS_LOAD_LSB +: N_CH]               = load_cap;       // [R12]
      word_d[`BFS_UV_BIT] = (bat_q == bfs_pkg::BFS_BAT_UNDER);      // [R5] [R8]
      word_d[`BFS_OV_BIT] = (bat_q == bfs_pkg::BFS_BAT_OVER);       // [R10]
    end

    // Flag holds until a chip-select fall finds nothing present
    // Only live faults hold the flag past a read; a load fault that has gone away does not
    fault_now = bat_fault | (|(load_fault_in & ~{N_CH{bat_fault}})) | other_fault_in; // [R7]
    flag_d    = fault_now | (flag_q & ~cs_fall);                     // [R2]
    flag_n_d  = ~flag_d;

    ref_d = ref_s;                                                   // [R9]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bat_q     <= bfs_pkg::BFS_BAT_OK;
      cs_prev_q <= `BFS_CS_RST;
      gate_q    <= '0;
      sticky_q  <= '0;
      word_q    <= '0;
      flag_q    <= `BFS_FLAG_RST;
      flag_n_q  <= `BFS_FLAG_N_RST;
      ref_q     <= `BFS_REF_RST;
    end else begin
      bat_q     <= bat_d;
      cs_prev_q <= cs_prev_d;
      gate_q    <= gate_d;
      sticky_q  <= sticky_d;
      word_q    <= word_d;
      flag_q    <= flag_d;
      flag_n_q  <= flag_n_d;
      ref_q     <= ref_d;
    end
  end

  assign gate_drive_outputs = gate_q;
  assign fault_word         = word_q;
  assign ref_select_ext     = ref_q;
  // Pin driven low only while flagged, so several devices can share the wire
  assign fault_flag_n_o     = flag_n_q;
  assign fault_flag_n_oe    = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sync_uv;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(uv_bat_in) |-> ##2 uv_s;
  endproperty
  a_sync_uv: assert property (p_sync_uv) else $error("uv not synchronised in 2"); // [R13]

  property p_uv_lock;
    @(posedge clk_sys) disable iff (sys_rst)
    uv_s && !ov_s |-> ##2 (gate_drive_outputs == '0);
  endproperty
  a_uv_lock: assert property (p_uv_lock) else $error("gates on in under-battery"); // [R3]

  property p_ov_lock;
    @(posedge clk_sys) disable iff (sys_rst)
    ov_s |-> ##2 (gate_drive_outputs == '0);
  endproperty
  a_ov_lock: assert property (p_ov_lock) else $error("gates on in over-battery"); // [R11]

  property p_resume;
    @(posedge clk_sys) disable iff (sys_rst)
    !uv_s && !ov_s ##1 bat_q == bfs_pkg::BFS_BAT_OK |=>
      gate_drive_outputs == $past(gate_cmd);
  endproperty
  a_resume: assert property (p_resume) else $error("gates not following command"); // [R4]

  property p_uv_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    cs_fall && bat_q == bfs_pkg::BFS_BAT_UNDER |=> fault_word[`BFS_UV_BIT];
  endproperty
  a_uv_bit: assert property (p_uv_bit) else $error("under-battery bit missing"); // [R5]

  property p_uv_gone;
    @(posedge clk_sys) disable iff (sys_rst)
    cs_fall && bat_q != bfs_pkg::BFS_BAT_UNDER |=> !fault_word[`BFS_UV_BIT];
  endproperty
  a_uv_gone: assert property (p_uv_gone) else $error("stale under-battery bit"); // [R8]

  property p_ov_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    cs_fall |=> fault_word[`BFS_OV_BIT] == $past(bat_q == bfs_pkg::BFS_BAT_OVER);
  endproperty
  a_ov_bit: assert property (p_ov_bit) else $error("over-battery bit wrong"); // [R10]

  property p_suppress;
    @(posedge clk_sys) disable iff (sys_rst)
    cs_fall && bat_fault |=> fault_word[`BFS_LOAD_LSB +: N_CH] == '0;
  endproperty
  a_suppress: assert property (p_suppress) else $error("load fault during battery fault"); // [R6]

  property p_load_report;
    @(posedge clk_sys) disable iff (sys_rst)
    cs_fall && !bat_fault |=>
      fault_word[`BFS_LOAD_LSB +: N_CH] == $past(sticky_q | load_fault_in);
  endproperty
  a_load_report: assert property (p_load_report) else $error("load faults not reported"); // [R1]

  property p_flag_set;
    @(posedge clk_sys) disable iff (sys_rst)
    bat_fault |=> fault_flag_n_oe && !fault_flag_n_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not asserted"); // [R7]

  property p_flag_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    flag_q && cs_fall && !fault_now |=> !fault_flag_n_oe && fault_flag_n_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not released"); // [R2]

  property p_flag_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    flag_q && !cs_fall |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without read"); // [R2]

  c_uv_episode: cover property (@(posedge clk_sys) disable iff (sys_rst)
    bat_q == bfs_pkg::BFS_BAT_UNDER ##[1:20] bat_q == bfs_pkg::BFS_BAT_OK);
  c_flag_release: cover property (@(posedge clk_sys) disable iff (sys_rst)
    flag_q ##1 cs_fall ##1 !flag_q);
  c_load_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
    cs_fall && (|load_cap));

endmodule : bfs_supervisor

`default_nettype wire

// File: core/bfs_cfg.svh
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// Fault word layout
`define BFS_NUM_CH      6
`define BFS_WORD_W      9
`define BFS_LOAD_LSB    0
`define BFS_UV_BIT      7
`define BFS_OV_BIT      8

// Analog thresholds behind the comparator inputs, in millivolts
`define BFS_UV_MV       4800
`define BFS_OV_MV       34000
`define BFS_INT_REF_MV  1250

// Synchroniser lanes: {ext_ref_select, cs_n, ov, uv}
`define BFS_SYNC_W      4
`define BFS_SYNC_RST    4'h4
`define BFS_SY_UV       0
`define BFS_SY_OV       1
`define BFS_SY_CS       2
`define BFS_SY_REF      3

// Reset values
`define BFS_FLAG_RST    1'h0
`define BFS_FLAG_N_RST  1'h1
`define BFS_CS_RST      1'h1
`define BFS_REF_RST     1'h0

`endif

// File: core/bfs_pkg.sv
package bfs_pkg;

  typedef enum logic [1:0] {
    BFS_BAT_OK    = 2'b00,
    BFS_BAT_UNDER = 2'b01,
    BFS_BAT_OVER  = 2'b10
  } bfs_bat_e;

endpackage : bfs_pkg

// File: core/bfs_sync.sv
`timescale 1ns/1ns
`default_nettype none

module bfs_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Lanes
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Two flops per lane; the first is read only by the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta_q;
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q      <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_q      <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule : bfs_sync

`default_nettype wire

// File: bench/bfs_mcu_model.sv
`timescale 1ns/1ns
`default_nettype none

module bfs_mcu_model (
  // Clock
  input  wire logic clk_sys,
  // Open-drain flag from the supervisor
  input  wire logic fault_flag_n_o,
  input  wire logic fault_flag_n_oe,
  // Controller side
  output var  logic cs_n,
  output var  logic flag_wire
);
  // Pull-up on the flag line, so a released pin reads high
  assign flag_wire = fault_flag_n_oe ? fault_flag_n_o : 1'h1;

  initial begin
    cs_n = 1'h1;
  end

  // Low time is a knob so reads can be quick or slow
  task automatic read_word(input int low_cyc);
    @(posedge clk_sys);
    cs_n <= 1'h0;
    repeat (low_cyc) @(posedge clk_sys);
    cs_n <= 1'h1;
    repeat (6) @(posedge clk_sys);
  endtask : read_word
endmodule : bfs_mcu_model

`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfs_cfg.svh"

module testbench;
  logic       clk_sys, sys_rst, uv, ov, cs_n, ext_sel, other, flag_wire, ref_ext, fo, foe;
  logic [5:0] gate_cmd, load, gates;
  logic [8:0] word;
  int         miscompares = 0;
  int         n_compared  = 0;
  int         cycles      = 0;

  bfs_supervisor dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .uv_bat_in(uv), .ov_bat_in(ov), .cs_n(cs_n),
    .ext_ref_select(ext_sel), .gate_cmd(gate_cmd), .load_fault_in(load),
    .other_fault_in(other), .gate_drive_outputs(gates), .fault_word(word),
    .ref_select_ext(ref_ext), .fault_flag_n_o(fo), .fault_flag_n_oe(foe));

  bfs_mcu_model mcu_u (
    .clk_sys(clk_sys), .fault_flag_n_o(fo), .fault_flag_n_oe(foe), .cs_n(cs_n),
    .flag_wire(flag_wire));

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Hang guard, well above the roughly 150 cycles the scenarios need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Outputs are looked at half a period after the edge that launched them
  task automatic look();
    @(negedge clk_sys);
  endtask : look

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // Every scenario starts on a rising edge and drives inputs there
  task automatic t_under();
    cyc(1);
    gate_cmd <= 6'h2A;
    cyc(2);
    look();
    chk("gates", 9'h02A, {3'h0, gates});
    cyc(1);
    gate_cmd <= 6'h3F;
    uv       <= 1'h1;
    // Two sync flops and the state register leave the gates on for three edges
    cyc(3);
    look();
    chk("gates", 9'h03F, {3'h0, gates});
    chk("flag", 9'h001, {8'h00, flag_wire});
    cyc(1);
    look();
    chk("gates", 9'h000, {3'h0, gates});
    chk("flag", 9'h000, {8'h00, flag_wire});
    cyc(1);
    load <= 6'h04;
    mcu_u.read_word(2);
    look();
    chk("word", 9'h080, word);
    cyc(1);
    uv <= 1'h0;
    cyc(3);
    look();
    chk("gates", 9'h000, {3'h0, gates});
    cyc(1);
    look();
    chk("gates", 9'h03F, {3'h0, gates});
    chk("flag", 9'h000, {8'h00, flag_wire});
    cyc(1);
    load     <= 6'h00;
    gate_cmd <= 6'h15;
    cyc(1);
    look();
    chk("gates", 9'h015, {3'h0, gates});
    mcu_u.read_word(2);
    look();
    chk("word", 9'h004, word);
    chk("flag", 9'h001, {8'h00, flag_wire});
  endtask : t_under

  task automatic t_over();
    cyc(1);
    other <= 1'h1;
    ov    <= 1'h1;
    cyc(3);
    look();
    chk("gates", 9'h015, {3'h0, gates});
    cyc(1);
    look();
    chk("gates", 9'h000, {3'h0, gates});
    mcu_u.read_word(3);
    look();
    chk("word", 9'h100, word);
    cyc(1);
    ov <= 1'h0;
    cyc(4);
    look();
    chk("gates", 9'h015, {3'h0, gates});
    mcu_u.read_word(2);
    look();
    chk("word", 9'h000, word);
    chk("flag", 9'h000, {8'h00, flag_wire});
    cyc(1);
    other <= 1'h0;
    mcu_u.read_word(2);
    look();
    chk("flag", 9'h001, {8'h00, flag_wire});
  endtask : t_over

  task automatic t_gone();
    cyc(1);
    uv <= 1'h1;
    cyc(5);
    uv <= 1'h0;
    cyc(5);
    look();
    chk("flag", 9'h000, {8'h00, flag_wire});
    mcu_u.read_word(2);
    look();
    chk("word", 9'h000, word);
    chk("flag", 9'h001, {8'h00, flag_wire});
  endtask : t_gone

  task automatic t_ref();
    cyc(1);
    ext_sel <= 1'h1;
    cyc(3);
    look();
    chk("ref", 9'h001, {8'h00, ref_ext});
    cyc(1);
    ext_sel <= 1'h0;
    cyc(3);
    look();
    chk("ref", 9'h000, {8'h00, ref_ext});
  endtask : t_ref

  task automatic t_load();
    cyc(1);
    load <= 6'h2A;
    cyc(3);
    load <= 6'h00;
    cyc(2);
    look();
    chk("flag", 9'h000, {8'h00, flag_wire});
    mcu_u.read_word(2);
    look();
    chk("word", 9'h02A, word);
    chk("flag", 9'h001, {8'h00, flag_wire});
    mcu_u.read_word(2);
    look();
    chk("word", 9'h000, word);
  endtask : t_load

  // Reset in mid-run with a fault flagged and a word captured
  task automatic t_reset();
    cyc(1);
    ext_sel <= 1'h1;
    load    <= 6'h01;
    mcu_u.read_word(2);
    look();
    chk("word", 9'h001, word);
    chk("ref", 9'h001, {8'h00, ref_ext});
    chk("flag", 9'h000, {8'h00, flag_wire});
    cyc(1);
    sys_rst <= 1'h1;
    look();
    chk("gates", 9'h000, {3'h0, gates});
    chk("word", 9'h000, word);
    chk("ref", 9'h000, {8'h00, ref_ext});
    chk("flag", 9'h001, {8'h00, flag_wire});
    cyc(1);
    load <= 6'h00;
    cyc(1);
    sys_rst <= 1'h0;
    cyc(3);
    look();
    chk("gates", 9'h015, {3'h0, gates});
    chk("word", 9'h000, word);
    chk("ref", 9'h001, {8'h00, ref_ext});
    chk("flag", 9'h001, {8'h00, flag_wire});
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst  = 1'h1;
    uv       = 1'h0;
    ov       = 1'h0;
    ext_sel  = 1'h0;
    other    = 1'h0;
    gate_cmd = 6'h00;
    load     = 6'h00;
    cyc(3);
    sys_rst <= 1'h0;
    cyc(2);
    t_under();
    t_over();
    t_gone();
    t_ref();
    t_load();
    t_reset();
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
